// *** include/sgcr_pkg.sv ***
`default_nettype none
// ----------------------------------------------------------------
// Global configuration bank, offsets 0x0B to 0x0F
// ----------------------------------------------------------------
package sgcr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_MGMT_CLOCK_SELECT = 8'h0b;
  localparam logic [7:0] OFF_PRIORITY_MAP_LOW = 8'h0c;
  localparam logic [7:0] OFF_PRIORITY_MAP_HIGH = 8'h0d;
  localparam logic [7:0] OFF_UNKNOWN_DEST_FORWARDING = 8'h0e;
  localparam logic [7:0] OFF_PHY_BASE_ADDRESS = 8'h0f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CLK_SEL_LSB = 6;
  localparam int CLK_SEL_WIDTH = 2;
  localparam int CLK_RSVD_LSB = 2;
  localparam int UNK_EN_BIT = 7;
  localparam int PAD_DRIVE_BIT = 6;
  localparam int UNK_MASK_LSB = 0;
  localparam int PORT_COUNT = 3;
  localparam int PHY_ADDR_LSB = 3;
  localparam int PHY_ADDR_WIDTH = 5;
  localparam int PRIO_WIDTH = 2;

  // ----------------------------------------------------------------
  // Interface clock select codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SGCR_CLK_31M25 = 2'h0,
    SGCR_CLK_62M5 = 2'h1,
    SGCR_CLK_125M = 2'h2
  } sgcr_clk_sel_t;

  // ----------------------------------------------------------------
  // Values after reset, and PHY address codes refused on write
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_CLK_SEL = 2'h2;
  localparam logic [1:0] RST_CLK_RSVD = 2'h2;
  localparam logic [7:0] RST_PRIO_LOW = 8'h50;
  localparam logic [7:0] RST_PRIO_HIGH = 8'hfa;
  localparam logic RST_UNK_EN = 1'b0;
  localparam logic RST_PAD_DRIVE = 1'b1;
  localparam logic [2:0] RST_UNK_MASK = 3'h7;
  localparam logic [4:0] RST_PHY_ADDR = 5'h01;
  localparam logic [4:0] PHY_ADDR_NONE = 5'h00;
  localparam logic [4:0] PHY_ADDR_TOP_A = 5'h1e;
  localparam logic [4:0] PHY_ADDR_TOP_B = 5'h1f;

endpackage : sgcr_pkg
`default_nettype wire

// *** rtl/sgcr_prio_lookup.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// 802.1p tag to egress queue priority lookup
// ----------------------------------------------------------------
module sgcr_prio_lookup (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] prioMapLow,
  input wire logic [7:0] prioMapHigh,
  input wire logic pcpValid,
  input wire logic [2:0] pcp,
  output logic framePrioValid,
  output logic [1:0] framePrio
);

  logic next_framePrioValid;
  logic [1:0] next_framePrio;
  logic [15:0] fullMap;

  // Pick the two-bit field of one tag value from the packed map
  function automatic logic [1:0] pickPrio(input logic [15:0] map,
                                          input logic [2:0] tag);
    pickPrio = map[{tag, 1'b0} +: 2];
  endfunction : pickPrio

  // Lower tag values sit in lower bits, so the low register goes last, in the bottom byte
  // tag field select
  assign fullMap = {prioMapHigh, prioMapLow};

  // Next lookup result
  always_comb begin
    next_framePrioValid = pcpValid;
    next_framePrio = framePrio;
    if (pcpValid) begin
      next_framePrio = pickPrio(fullMap, pcp);
    end
  end

  // Result is registered; it holds until the next valid tag
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      framePrioValid <= 1'b0;
      framePrio <= 2'h0;
    end else begin
      framePrioValid <= next_framePrioValid;
      framePrio <= next_framePrio;
    end
  end

endmodule : sgcr_prio_lookup
`default_nettype wire

// *** rtl/sgcr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module sgcr_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register access from the management serial decoder
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic regHit,
  output logic regRdValid,
  output logic [7:0] regRdData,
  // Management interface clock choice
  output logic [1:0] mgmtClkSel,
  // Priority lookup for tagged ingress frames
  input wire logic pcpValid,
  input wire logic [2:0] pcp,
  output logic framePrioValid,
  output logic [1:0] framePrio,
  // Forwarding decision for a lookup miss
  input wire logic missValid,
  input wire logic [2:0] missDefaultPorts,
  output logic missPortsValid,
  output logic [2:0] missPorts,
  // PHY management addresses
  output logic [4:0] phyAddrPort1,
  output logic [4:0] phyAddrPort2
);

  // ----------------------------------------------------------------
  // Stored fields
  // ----------------------------------------------------------------
  logic [1:0] clkSel;
  logic [1:0] next_clkSel;
  logic [1:0] prio_map_pcp_zero;
  logic [1:0] prio_map_pcp_one;
  logic [1:0] prio_map_pcp_two;
  logic [1:0] prio_map_pcp_three;
  logic [1:0] prio_map_pcp_four;
  logic [1:0] prio_map_pcp_five;
  logic [1:0] prio_map_pcp_six;
  logic [1:0] prio_map_pcp_seven;
  logic [7:0] prioLow;
  logic [7:0] prioHigh;
  logic [7:0] next_prioLow;
  logic [7:0] next_prioHigh;
  logic unkEn;
  logic next_unkEn;
  logic padDrive;
  logic next_padDrive;
  logic [2:0] unkMask;
  logic [2:0] next_unkMask;
  logic [4:0] phyAddr;
  logic [4:0] next_phyAddr;

  // Read and forwarding output state
  logic next_regRdValid;
  logic [7:0] next_regRdData;
  logic next_missPortsValid;
  logic [2:0] next_missPorts;
  logic [4:0] next_phyAddrPort1;
  logic [4:0] next_phyAddrPort2;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Address hit test, drives only the regHit output; the write and read paths decode regAddr in their own case statements
  function automatic logic isOwnOffset(input logic [7:0] addr);
    isOwnOffset = (addr == sgcr_pkg::OFF_MGMT_CLOCK_SELECT) ||
                  (addr == sgcr_pkg::OFF_PRIORITY_MAP_LOW) ||
                  (addr == sgcr_pkg::OFF_PRIORITY_MAP_HIGH) ||
                  (addr == sgcr_pkg::OFF_UNKNOWN_DEST_FORWARDING) ||
                  (addr == sgcr_pkg::OFF_PHY_BASE_ADDRESS);
  endfunction : isOwnOffset

  // Codes with no PHY behind them; also guards the port 2 overflow
  function automatic logic isPhyAddrLegal(input logic [4:0] addr);
    isPhyAddrLegal = (addr != sgcr_pkg::PHY_ADDR_NONE) &&
                     (addr != sgcr_pkg::PHY_ADDR_TOP_A) &&
                     (addr != sgcr_pkg::PHY_ADDR_TOP_B);
  endfunction : isPhyAddrLegal

  // Named views of the map fields
  assign prio_map_pcp_zero = prioLow[1:0];
  assign prio_map_pcp_one = prioLow[3:2];
  assign prio_map_pcp_two = prioLow[5:4];
  assign prio_map_pcp_three = prioLow[7:6];
  assign prio_map_pcp_four = prioHigh[1:0];
  assign prio_map_pcp_five = prioHigh[3:2];
  assign prio_map_pcp_six = prioHigh[5:4];
  assign prio_map_pcp_seven = prioHigh[7:6];

  assign regHit = isOwnOffset(regAddr);
  assign mgmtClkSel = clkSel;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Only the writable fields take data; reserved bits are not stored
  always_comb begin
    next_clkSel = clkSel;
    next_prioLow = prioLow;
    next_prioHigh = prioHigh;
    next_unkEn = unkEn;
    next_padDrive = padDrive;
    next_unkMask = unkMask;
    next_phyAddr = phyAddr;
    if (regWrEn) begin
      unique case (regAddr)
        sgcr_pkg::OFF_MGMT_CLOCK_SELECT: begin
          next_clkSel = regWrData[sgcr_pkg::CLK_SEL_LSB +:
                                  sgcr_pkg::CLK_SEL_WIDTH];
        end
        sgcr_pkg::OFF_PRIORITY_MAP_LOW: begin
          next_prioLow = regWrData;
        end
        sgcr_pkg::OFF_PRIORITY_MAP_HIGH: begin
          next_prioHigh = regWrData;
        end
        sgcr_pkg::OFF_UNKNOWN_DEST_FORWARDING: begin
          next_unkEn = regWrData[sgcr_pkg::UNK_EN_BIT];
          next_padDrive = regWrData[sgcr_pkg::PAD_DRIVE_BIT];
          next_unkMask = regWrData[sgcr_pkg::UNK_MASK_LSB +:
                                   sgcr_pkg::PORT_COUNT];
        end
        sgcr_pkg::OFF_PHY_BASE_ADDRESS: begin
          if (isPhyAddrLegal(regWrData[sgcr_pkg::PHY_ADDR_LSB +:
                                       sgcr_pkg::PHY_ADDR_WIDTH])) begin
            next_phyAddr = regWrData[sgcr_pkg::PHY_ADDR_LSB +:
                                     sgcr_pkg::PHY_ADDR_WIDTH];
          end
        end
        default: begin
          // Offsets of other banks are left to their owners
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clkSel <= sgcr_pkg::RST_CLK_SEL;
      prioLow <= sgcr_pkg::RST_PRIO_LOW;
      prioHigh <= sgcr_pkg::RST_PRIO_HIGH;
      unkEn <= sgcr_pkg::RST_UNK_EN;
      padDrive <= sgcr_pkg::RST_PAD_DRIVE;
      unkMask <= sgcr_pkg::RST_UNK_MASK;
      phyAddr <= sgcr_pkg::RST_PHY_ADDR;
    end else begin
      clkSel <= next_clkSel;
      prioLow <= next_prioLow;
      prioHigh <= next_prioHigh;
      unkEn <= next_unkEn;
      padDrive <= next_padDrive;
      unkMask <= next_unkMask;
      phyAddr <= next_phyAddr;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------

  // Read data is registered; misses return zero so an outer mux may OR
  always_comb begin
    next_regRdValid = regRdEn;
    next_regRdData = 8'h00;
    if (regRdEn) begin
      unique case (regAddr)
        sgcr_pkg::OFF_MGMT_CLOCK_SELECT: begin
          next_regRdData[sgcr_pkg::CLK_SEL_LSB +:
                         sgcr_pkg::CLK_SEL_WIDTH] = clkSel;
          next_regRdData[sgcr_pkg::CLK_RSVD_LSB +: 2] =
            sgcr_pkg::RST_CLK_RSVD;
        end
        sgcr_pkg::OFF_PRIORITY_MAP_LOW: begin
          next_regRdData = {prio_map_pcp_three, prio_map_pcp_two,
                            prio_map_pcp_one, prio_map_pcp_zero};
        end
        sgcr_pkg::OFF_PRIORITY_MAP_HIGH: begin
          next_regRdData = {prio_map_pcp_seven, prio_map_pcp_six,
                            prio_map_pcp_five, prio_map_pcp_four};
        end
        sgcr_pkg::OFF_UNKNOWN_DEST_FORWARDING: begin
          next_regRdData[sgcr_pkg::UNK_EN_BIT] = unkEn;
          next_regRdData[sgcr_pkg::PAD_DRIVE_BIT] = padDrive;
          next_regRdData[sgcr_pkg::UNK_MASK_LSB +:
                         sgcr_pkg::PORT_COUNT] = unkMask;
        end
        sgcr_pkg::OFF_PHY_BASE_ADDRESS: begin
          next_regRdData[sgcr_pkg::PHY_ADDR_LSB +:
                         sgcr_pkg::PHY_ADDR_WIDTH] = phyAddr;
        end
        default: begin
          next_regRdData = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regRdValid <= 1'b0;
      regRdData <= 8'h00;
    end else begin
      regRdValid <= next_regRdValid;
      regRdData <= next_regRdData;
    end
  end

  // ----------------------------------------------------------------
  // Lookup-miss forwarding and PHY addresses
  // ----------------------------------------------------------------

  // The mask replaces the normal flood set only while enabled
  always_comb begin
    next_missPortsValid = missValid;
    next_missPorts = missPorts;
    if (missValid) begin
      if (unkEn) begin
        next_missPorts = unkMask;
      end else begin
        next_missPorts = missDefaultPorts;
      end
    end
    // Stored address is always legal, so the increment never wraps
    next_phyAddrPort1 = phyAddr;
    next_phyAddrPort2 = 5'(phyAddr + 5'h01);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      missPortsValid <= 1'b0;
      missPorts <= 3'h0;
      phyAddrPort1 <= sgcr_pkg::RST_PHY_ADDR;
      phyAddrPort2 <= 5'(sgcr_pkg::RST_PHY_ADDR + 5'h01);
    end else begin
      missPortsValid <= next_missPortsValid;
      missPorts <= next_missPorts;
      phyAddrPort1 <= next_phyAddrPort1;
      phyAddrPort2 <= next_phyAddrPort2;
    end
  end

  // ----------------------------------------------------------------
  // Priority lookup
  // ----------------------------------------------------------------

  sgcr_prio_lookup u_prio (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .prioMapLow(prioLow),
    .prioMapHigh(prioHigh),
    .pcpValid(pcpValid),
    .pcp(pcp),
    .framePrioValid(framePrioValid),
    .framePrio(framePrio)
  );

endmodule : sgcr_regs
`default_nettype wire

// *** sim/sgcr_regs_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port-level checks of the configuration bank
// ----------------------------------------------------------------
module sgcr_regs_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic regHit,
  input wire logic regRdValid,
  input wire logic [7:0] regRdData,
  input wire logic [1:0] mgmtClkSel,
  input wire logic pcpValid,
  input wire logic [2:0] pcp,
  input wire logic framePrioValid,
  input wire logic [1:0] framePrio,
  input wire logic missValid,
  input wire logic [2:0] missDefaultPorts,
  input wire logic missPortsValid,
  input wire logic [2:0] missPorts,
  input wire logic [4:0] phyAddrPort1,
  input wire logic [4:0] phyAddrPort2
);
  logic [15:0] prioMap;
  logic [15:0] next_prioMap;
  logic [3:0] unkCfg;
  logic [3:0] next_unkCfg;
  logic [1:0] prioPick;
  logic [2:0] missPick;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Shadow of map and forwarding fields, built only from port traffic
  always_comb begin
    next_prioMap = prioMap;
    next_unkCfg = unkCfg;
    if (regWrEn && regAddr == 8'h0c) next_prioMap[7:0] = regWrData;
    if (regWrEn && regAddr == 8'h0d) next_prioMap[15:8] = regWrData;
    if (regWrEn && regAddr == 8'h0e) next_unkCfg = {regWrData[7], regWrData[2:0]};
    if (!rst_n) next_prioMap = 16'hfa50;
    if (!rst_n) next_unkCfg = 4'h7;
    prioPick = prioMap[2*pcp +: 2];
    missPick = unkCfg[3] ? unkCfg[2:0] : missDefaultPorts;
  end
  always_ff @(posedge clk_sys) begin
    prioMap <= next_prioMap;
    unkCfg <= next_unkCfg;
  end
  AST_CLK_RESET: assert property ($rose(rst_n) |-> mgmtClkSel == 2'h2)
    else $error("clock select not 125 MHz after reset");
  AST_CLK_HOLD: assert property (rst_n && $past(rst_n) && !$stable(mgmtClkSel)
    |-> $past(regWrEn) && $past(regAddr) == 8'h0b) else $error("clock select moved");
  AST_PRIO_MAP: assert property (pcpValid |=> framePrioValid
    && framePrio == $past(prioPick)) else $error("wrong frame priority");
  AST_MISS_PORTS: assert property (missValid |=> missPortsValid
    && missPorts == $past(missPick)) else $error("wrong miss port set");
  AST_PHY_RESET: assert property ($rose(rst_n) |-> phyAddrPort1 == 5'h01)
    else $error("port 1 address not 1 after reset");
  AST_PHY_LEGAL: assert property (!(phyAddrPort1 inside {5'h00, 5'h1e, 5'h1f}))
    else $error("port 1 address holds an unusable code");
  AST_PHY_NEXT: assert property (phyAddrPort2 == phyAddrPort1 + 5'h01)
    else $error("port 2 address not base plus one");
  AST_RD_UNMAPPED: assert property (regRdEn && !regHit |=> regRdValid
    && regRdData == 8'h00) else $error("unmapped read not zero");
  AST_RD_RSVD: assert property (regRdEn && regAddr == 8'h0b |=>
    regRdData[5:0] == 6'h08) else $error("reserved bits of 0x0b wrong");
  AST_HIT: assert property (regHit ==
    (regAddr >= 8'h0b && regAddr <= 8'h0f)) else $error("offset hit wrong");
  AST_RD_IDLE: assert property (!regRdEn |=> !regRdValid
    && regRdData == 8'h00) else $error("read data not idle");
endmodule : sgcr_regs_checker

bind sgcr_regs sgcr_regs_checker u_sgcr_regs_checker (.clk_sys(clk_sys),
  .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdEn(regRdEn), .regHit(regHit), .regRdValid(regRdValid),
  .regRdData(regRdData), .mgmtClkSel(mgmtClkSel), .pcpValid(pcpValid),
  .pcp(pcp), .framePrioValid(framePrioValid), .framePrio(framePrio),
  .missValid(missValid), .missDefaultPorts(missDefaultPorts),
  .missPortsValid(missPortsValid), .missPorts(missPorts),
  .phyAddrPort1(phyAddrPort1), .phyAddrPort2(phyAddrPort2));
`default_nettype wire

// *** sim/sgcr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host side of the register path, changes lines at falling edges
// ----------------------------------------------------------------
module sgcr_host_model (
  input wire logic clk_sys,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  input wire logic regRdValid,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  // keep reserved defaults; raw=1 breaks this on purpose
  function automatic logic [7:0] keepRsvd(input logic [7:0] a, d);
    case (a)
      8'h0b: return {d[7:6], 6'h08};
      8'h0e: return d & 8'hc7;
      8'h0f: return {d[7:3], 3'h0};
      default: return d;
    endcase
  endfunction : keepRsvd
  // Write; random idle gap so both prompt and slow hosts are seen
  task automatic wr(input logic [7:0] a, d, input logic raw);
    repeat ($urandom_range(2, 0)) @(negedge clk_sys);
    @(negedge clk_sys);
    regAddr = a;
    regWrData = raw ? d : keepRsvd(a, d);
    regWrEn = 1'b1;
    @(negedge clk_sys);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~regWrData;
  endtask : wr
  // Read; answer is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_sys);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk_sys);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
    v = regRdValid;
  endtask : rd
  // drop to slowest clock when idle
  task automatic idleClock();
    wr(8'h0b, 8'h08, 1'b0);
  endtask : idleClock
endmodule : sgcr_host_model
`default_nettype wire

// *** sim/switch_global_config_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module switch_global_config_regs_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData, rdv;
  logic regWrEn, regRdEn, regHit, regRdValid, vld;
  logic [1:0] mgmtClkSel, framePrio;
  logic pcpValid = 1'b0;
  logic missValid = 1'b0;
  logic [2:0] pcp = 3'h0;
  logic [2:0] missDefaultPorts = 3'h0;
  logic framePrioValid, missPortsValid;
  logic [2:0] missPorts;
  logic [4:0] phyAddrPort1, phyAddrPort2;
  logic [7:0] mirror [256];
  logic [4:0] code;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  always #4 clk_sys = ~clk_sys;
  sgcr_regs u_sgcr_regs (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regHit(regHit), .regRdValid(regRdValid), .regRdData(regRdData),
    .mgmtClkSel(mgmtClkSel), .pcpValid(pcpValid), .pcp(pcp),
    .framePrioValid(framePrioValid), .framePrio(framePrio),
    .missValid(missValid), .missDefaultPorts(missDefaultPorts),
    .missPortsValid(missPortsValid), .missPorts(missPorts),
    .phyAddrPort1(phyAddrPort1), .phyAddrPort2(phyAddrPort2));
  sgcr_host_model u_sgcr_host_model (.clk_sys(clk_sys), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdValid(regRdValid), .regRdData(regRdData));
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Stored image of a write; illegal address codes drop the whole write
  function automatic logic [7:0] expStore(input logic [7:0] a, d, old);
    case (a)
      8'h0b: return {d[7:6], 6'h08};
      8'h0e: return d & 8'hc7;
      8'h0f: return d[7:3] inside {5'h00, 5'h1e, 5'h1f} ? old : {d[7:3], 3'h0};
      default: return d;
    endcase
  endfunction : expStore
  task automatic wrReg(input logic [7:0] a, d, input logic raw);
    u_sgcr_host_model.wr(a, d, raw);
    if (a inside {[8'h0b:8'h0f]}) mirror[a] = expStore(a, d, mirror[a]);
  endtask : wrReg
  task automatic rdChk(input logic [7:0] a);
    u_sgcr_host_model.rd(a, rdv, vld);
    chk("read valid", {7'h0, vld}, 8'h01);
    chk("read data", rdv, mirror[a]);
  endtask : rdChk
  task automatic prioChk(input logic [2:0] p);
    @(negedge clk_sys);
    pcpValid = 1'b1;
    pcp = p;
    @(negedge clk_sys);
    pcpValid = 1'b0;
    pcp = 3'($urandom);
    chk("priority", {framePrioValid, framePrio},
        {1'b1, 2'({mirror[8'h0d], mirror[8'h0c]} >> (2 * p))});
  endtask : prioChk
  task automatic missChk(input logic [2:0] dflt);
    @(negedge clk_sys);
    missValid = 1'b1;
    missDefaultPorts = dflt;
    @(negedge clk_sys);
    missValid = 1'b0;
    missDefaultPorts = ~dflt;
    chk("miss ports", {missPortsValid, missPorts}, {1'b1,
        mirror[8'h0e][7] ? mirror[8'h0e][2:0] : dflt});
  endtask : missChk
  // Hang guard, well above the length of the sequence
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(6715));
    foreach (mirror[i]) mirror[i] = 8'h00;
    mirror[8'h0b] = 8'h88;
    mirror[8'h0c] = 8'h50;
    mirror[8'h0d] = 8'hfa;
    mirror[8'h0e] = 8'h47;
    mirror[8'h0f] = 8'h08;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    chk("clock select", 8'(mgmtClkSel), 8'h02);
    chk("port 2 address", 8'(phyAddrPort2), 8'h02);
    for (int a = 8'h0a; a <= 8'h10; a++) rdChk(8'(a));
    for (int p = 0; p < 8; p++) prioChk(3'(p));
    for (int c = 0; c < 4; c++) begin
      wrReg(8'h0b, {2'(c), 6'($urandom)}, 1'b1);
      chk("clock select", 8'(mgmtClkSel), 8'(c));
      rdChk(8'h0b);
    end
    repeat (3) begin
      wrReg(8'h0c, 8'($urandom), 1'b0);
      wrReg(8'h0d, 8'($urandom), 1'b0);
      for (int p = 0; p < 8; p++) prioChk(3'(p));
    end
    repeat (3) missChk(3'($urandom));
    for (int m = 0; m < 8; m++) begin
      wrReg(8'h0e, {1'b1, 4'($urandom), 3'(m)}, 1'b1);
      missChk(3'($urandom));
      rdChk(8'h0e);
    end
    wrReg(8'h0e, 8'h05, 1'b0);
    missChk(3'h2);
    for (int k = 0; k < 9; k++) begin
      code = k < 3 ? 5'(k * 14 + 1) : k < 6 ? 5'($urandom_range(29, 1)) :
             k == 6 ? 5'h00 : k == 7 ? 5'h1e : 5'h1f;
      wrReg(8'h0f, {code, 3'($urandom)}, 1'b1);
      // The PHY address outputs trail the stored field by one cycle
      @(negedge clk_sys);
      chk("port 1 address", 8'(phyAddrPort1), 8'(mirror[8'h0f][7:3]));
      chk("port 2 address", 8'(phyAddrPort2),
          8'(mirror[8'h0f][7:3] + 5'h01));
      rdChk(8'h0f);
    end
    wrReg(8'h0a, 8'hff, 1'b1);
    wrReg(8'h10, 8'hff, 1'b1);
    for (int a = 8'h0a; a <= 8'h10; a++) rdChk(8'(a));
    u_sgcr_host_model.idleClock();
    chk("clock select", 8'(mgmtClkSel), 8'h00);
    end_sim();
  end
endmodule : switch_global_config_regs_tb_top
`default_nettype wire
